// ### rtl/scl_pkg.sv
// How it works
// RULE1: Straps are captured on power-on reset and pin reset, then become initial config.
// RULE2: Address strap is stored at reset end; with no drive it reads zero.
// RULE3: Management frames are answered only when their address equals the stored address.
// RULE4: The stored address seeds the transmit scrambler.
// RULE5: Straps give addresses 0 to 7; software may write larger ones later.
// RULE6: Address bits come from receive-error, receive-clock and receive-data-3 pins.
// RULE7: On pin reset release, control and advertisement bits load from the mode strap.
// RULE8: Soft reset reloads no strap; configuration keeps the current register contents.
// RULE9: Modes 000 and 001 force 10 Mb/s half and full duplex, no negotiation.
// RULE10: Modes 010 and 011 force 100 Mb/s half and full duplex, no negotiation.
// RULE11: Carrier sense covers transmit in half-duplex modes, receive only otherwise; the code leaves transmit out in repeater mode.
// RULE12: Mode 100 negotiates and advertises only 100 Mb/s half duplex.
// RULE13: Mode 101 is repeater mode with the same loads as mode 100.
// RULE14: Mode 110 powers down until another mode is written and soft reset issued; the code also wakes on a control write with the power-down bit clear.
// RULE15: Mode 111 negotiates and advertises every capability.
// RULE16: Mode bits come from receive data 0, receive data 1 and collision pins.
// RULE17: Interface select latches at reset release; low is MII, high is RMII.
// RULE18: The interface-mode bit loads from that strap and shows the active interface.
// RULE19: Straps are sampled with pin drivers off and held until the next reset.
package scl_pkg;
   // Register map, one 32-bit word each
   localparam int unsigned PADDR_W          = 8;
   localparam logic [7:0]  OFS_BASIC_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_ADVERT       = 8'h04;
   localparam logic [7:0]  OFS_SPECIAL      = 8'h08;
   localparam logic [7:0]  OFS_STRAP_STAT   = 8'h0C;
   // Basic control fields
   localparam int unsigned BC_SOFT_RST      = 15;
   localparam int unsigned BC_SPEED         = 13;
   localparam int unsigned BC_AN_EN         = 12;
   localparam int unsigned BC_PDOWN         = 11;
   localparam int unsigned BC_ISOLATE       = 10;
   localparam int unsigned BC_DUPLEX        = 8;
   // Advertisement and special modes fields
   localparam int unsigned ADV_LSB          = 5;
   localparam int unsigned ADV_W            = 4;
   localparam int unsigned SM_IFMODE        = 14;
   localparam int unsigned SM_MODE_LSB      = 5;
   localparam int unsigned SM_ADDR_LSB      = 0;
   localparam int unsigned PHY_ADDR_W       = 5;
   // Strap vector layout
   localparam int unsigned STRAP_W          = 7;
   localparam int unsigned STR_ADDR_LSB     = 0;
   localparam int unsigned STR_MODE_LSB     = 3;
   localparam int unsigned STR_RMII         = 6;
   // Mode strap codes
   localparam logic [2:0]  MODE_10_HALF     = 3'h0;
   localparam logic [2:0]  MODE_10_FULL     = 3'h1;
   localparam logic [2:0]  MODE_100_HALF    = 3'h2;
   localparam logic [2:0]  MODE_100_FULL    = 3'h3;
   localparam logic [2:0]  MODE_AN_100H     = 3'h4;
   localparam logic [2:0]  MODE_REPEATER    = 3'h5;
   localparam logic [2:0]  MODE_POWER_DOWN  = 3'h6;
   localparam logic [2:0]  MODE_ALL_CAP     = 3'h7;
   // Control loads, order speed, negotiate, isolate, duplex
   localparam logic [3:0]  CTRL_10_HALF     = 4'h0;
   localparam logic [3:0]  CTRL_10_FULL     = 4'h1;
   localparam logic [3:0]  CTRL_100_HALF    = 4'h8;
   localparam logic [3:0]  CTRL_100_FULL    = 4'h9;
   localparam logic [3:0]  CTRL_AN_100H     = 4'hC;
   localparam logic [3:0]  CTRL_ALL_CAP     = 4'hD;
   // Advertisement loads, bits 8 to 5
   localparam logic [3:0]  ADV_100_HALF     = 4'h4;
   localparam logic [3:0]  ADV_ALL_CAP      = 4'hF;
   // Reset values
   localparam logic [6:0]  STRAP_DEFAULT    = 7'h00;
   localparam logic [3:0]  ADV_RESET        = 4'hF;
endpackage : scl_pkg

// ### rtl/scl_strap_latch.sv
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module scl_strap_latch
(
   // Clock and resets
   input  wire logic                              CLK_SYS_I,
   input  wire logic                              RST_I,
   input  wire logic                              PIN_RESET_N_I,
   // Shared receive pins carrying straps during reset
   input  wire logic                              RX_ERR_I,
   input  wire logic                              RX_CLK_PIN_I,
   input  wire logic [3:0]                        RXD_I,
   input  wire logic                              COL_CRSDV_I,
   input  wire logic                              REDUCED_IF_SELECT_STRAP_I,
   output logic                                   RX_OE_O,
   // Activity and management frame inputs, and the address match output
   input  wire logic                              TX_ACTIVE_I,
   input  wire logic                              RX_ACTIVE_I,
   input  wire logic                              MGMT_FRAME_VALID_I,
   input  wire logic [scl_pkg::PHY_ADDR_W-1:0]    MGMT_FRAME_ADDR_I,
   output logic                                   MGMT_ADDR_MATCH_O,
   // Configuration outputs
   output logic [scl_pkg::PHY_ADDR_W-1:0]         PHY_ADDR_O,
   output logic [scl_pkg::PHY_ADDR_W-1:0]         SCRAMBLER_SEED_O,
   output logic                                   SPEED_100_O,
   output logic                                   AUTONEG_EN_O,
   output logic                                   ISOLATE_O,
   output logic                                   FULL_DUPLEX_O,
   output logic                                   POWER_DOWN_O,
   output logic [scl_pkg::ADV_W-1:0]              ADVERT_O,
   output logic                                   REPEATER_O,
   output logic                                   MEDIA_IF_MODE_BIT_O,
   output logic                                   CRS_O,
   // APB slave
   input  wire logic                              PSEL,
   input  wire logic                              PENABLE,
   input  wire logic                              PWRITE,
   input  wire logic [scl_pkg::PADDR_W-1:0]       PADDR,
   input  wire logic [31:0]                       PWDATA,
   output logic [31:0]                            PRDATA,
   output logic                                   PREADY,
   output logic                                   PSLVERR
);

   // Synchronisers for pin reset and straps
   logic                              pin_rst_n_s1;
   logic                              pin_rst_n_s2;
   logic [scl_pkg::STRAP_W-1:0]       strap_raw;
   logic [scl_pkg::STRAP_W-1:0]       strap_s1;
   logic [scl_pkg::STRAP_W-1:0]       strap_s2;

   // Register state
   logic [scl_pkg::STRAP_W-1:0]       cap_reg,    cap_next;
   logic                              in_rst_d_reg;
   logic                              rx_oe_reg,  rx_oe_next;
   logic [scl_pkg::PHY_ADDR_W-1:0]    addr_reg,   addr_next;
   logic [2:0]                        mode_reg,   mode_next;
   logic                              ifmode_reg, ifmode_next;
   logic                              speed_reg,  speed_next;
   logic                              an_reg,     an_next;
   logic                              iso_reg,    iso_next;
   logic                              dup_reg,    dup_next;
   logic                              pdown_reg,  pdown_next;
   logic [scl_pkg::ADV_W-1:0]         adv_reg,    adv_next;
   logic                              rep_reg,    rep_next;
   logic                              crs_reg,    crs_next;
   logic                              match_reg,  match_next;
   logic                              pready_reg, pready_next;
   logic                              perr_reg,   perr_next;
   logic [31:0]                       prdata_reg, prdata_next;

   logic                              in_reset;
   logic                              release_evt;
   logic                              wr_acc;
   logic                              soft_rst;
   logic [2:0]                        cap_mode;
   logic [3:0]                        ctrl_load;
   logic [scl_pkg::ADV_W-1:0]         adv_load;
   logic                              addr_hit;

   // Pin order puts the strap groups at their package positions
   assign strap_raw = {REDUCED_IF_SELECT_STRAP_I,
                       COL_CRSDV_I, RXD_I[1], RXD_I[0],          // RULE16
                       RXD_I[3], RX_CLK_PIN_I, RX_ERR_I};        // RULE6

   always_ff @(posedge CLK_SYS_I)
   begin
      pin_rst_n_s1 <= PIN_RESET_N_I;
      pin_rst_n_s2 <= pin_rst_n_s1;
      strap_s1     <= strap_raw;
      strap_s2     <= strap_s1;
   end

   // Either reset source opens the capture window
   assign in_reset    = RST_I | ~pin_rst_n_s2;                   // RULE1
   assign release_evt = in_rst_d_reg & ~in_reset;
   assign cap_mode    = cap_reg[scl_pkg::STR_MODE_LSB +: 3];
   assign wr_acc      = PSEL & PENABLE & pready_reg & PWRITE & ~in_reset;
   assign soft_rst    = wr_acc & (PADDR == scl_pkg::OFS_BASIC_CTRL)
                        & PWDATA[scl_pkg::BC_SOFT_RST];

   // Mode strap decode into control and advertisement loads
   always_comb
   begin
      ctrl_load = scl_pkg::CTRL_ALL_CAP;
      adv_load  = scl_pkg::ADV_RESET;
      case (cap_mode)
         scl_pkg::MODE_10_HALF:  ctrl_load = scl_pkg::CTRL_10_HALF;   // RULE9
         scl_pkg::MODE_10_FULL:  ctrl_load = scl_pkg::CTRL_10_FULL;   // RULE9
         scl_pkg::MODE_100_HALF: ctrl_load = scl_pkg::CTRL_100_HALF;  // RULE10
         scl_pkg::MODE_100_FULL: ctrl_load = scl_pkg::CTRL_100_FULL;  // RULE10
         scl_pkg::MODE_AN_100H,
         scl_pkg::MODE_REPEATER:
         begin
            ctrl_load = scl_pkg::CTRL_AN_100H;                        // RULE12 RULE13
            adv_load  = scl_pkg::ADV_100_HALF;                        // RULE12 RULE13
         end
         scl_pkg::MODE_ALL_CAP:
         begin
            ctrl_load = scl_pkg::CTRL_ALL_CAP;                        // RULE15
            adv_load  = scl_pkg::ADV_ALL_CAP;                         // RULE15
         end
         default:
         begin
            ctrl_load = scl_pkg::CTRL_ALL_CAP;
            adv_load  = scl_pkg::ADV_RESET;
         end
      endcase
   end

   // Next state of the strap capture and configuration registers
   always_comb
   begin
      cap_next    = cap_reg;
      rx_oe_next  = ~in_reset;                                        // RULE19
      addr_next   = addr_reg;
      mode_next   = mode_reg;
      ifmode_next = ifmode_reg;
      speed_next  = speed_reg;
      an_next     = an_reg;
      iso_next    = iso_reg;
      dup_next    = dup_reg;
      pdown_next  = pdown_reg;
      adv_next    = adv_reg;
      rep_next    = rep_reg;
      // Sampling only while drivers are off avoids reading our own outputs
      if (in_reset)
      begin
         cap_next = strap_s2;                                         // RULE19
      end
      if (release_evt)
      begin
         addr_next   = {2'h0, cap_reg[scl_pkg::STR_ADDR_LSB +: 3]};   // RULE2 RULE5
         mode_next   = cap_mode;
         ifmode_next = cap_reg[scl_pkg::STR_RMII];                    // RULE17 RULE18
         speed_next  = ctrl_load[3];                                  // RULE7
         an_next     = ctrl_load[2];                                  // RULE7
         iso_next    = ctrl_load[1];                                  // RULE7
         dup_next    = ctrl_load[0];                                  // RULE7
         adv_next    = adv_load;                                      // RULE7
         pdown_next  = (cap_mode == scl_pkg::MODE_POWER_DOWN);        // RULE14
         rep_next    = (cap_mode == scl_pkg::MODE_REPEATER);          // RULE13
      end
      else if (wr_acc)
      begin
         if (PADDR == scl_pkg::OFS_BASIC_CTRL)
         begin
            speed_next = PWDATA[scl_pkg::BC_SPEED];
            an_next    = PWDATA[scl_pkg::BC_AN_EN];
            iso_next   = PWDATA[scl_pkg::BC_ISOLATE];
            dup_next   = PWDATA[scl_pkg::BC_DUPLEX];
            // Soft reset keeps the straps and rereads the mode field
            if (soft_rst)
            begin
               pdown_next = (mode_reg == scl_pkg::MODE_POWER_DOWN);   // RULE8 RULE14
               rep_next   = (mode_reg == scl_pkg::MODE_REPEATER);     // RULE8
            end
            else
            begin
               pdown_next = PWDATA[scl_pkg::BC_PDOWN];
            end
         end
         else if (PADDR == scl_pkg::OFS_ADVERT)
         begin
            adv_next = PWDATA[scl_pkg::ADV_LSB +: scl_pkg::ADV_W];
         end
         else if (PADDR == scl_pkg::OFS_SPECIAL)
         begin
            addr_next = PWDATA[scl_pkg::SM_ADDR_LSB +: scl_pkg::PHY_ADDR_W]; // RULE5
            mode_next = PWDATA[scl_pkg::SM_MODE_LSB +: 3];            // RULE14
         end
      end
   end

   // Frame match, carrier sense and bus answer
   always_comb
   begin
      addr_hit    = (MGMT_FRAME_ADDR_I == addr_reg);
      match_next  = MGMT_FRAME_VALID_I & addr_hit & ~in_reset;        // RULE3
      crs_next    = RX_ACTIVE_I
                    | (TX_ACTIVE_I & ~dup_reg & ~rep_reg);            // RULE11
      pready_next = PSEL & ~PENABLE;
      perr_next   = 1'b0;
      prdata_next = 32'h0000_0000;
      if (PSEL & ~PENABLE)
      begin
         if (PADDR == scl_pkg::OFS_BASIC_CTRL)
         begin
            prdata_next[scl_pkg::BC_SPEED]   = speed_reg;
            prdata_next[scl_pkg::BC_AN_EN]   = an_reg;
            prdata_next[scl_pkg::BC_PDOWN]   = pdown_reg;
            prdata_next[scl_pkg::BC_ISOLATE] = iso_reg;
            prdata_next[scl_pkg::BC_DUPLEX]  = dup_reg;
         end
         else if (PADDR == scl_pkg::OFS_ADVERT)
         begin
            prdata_next[scl_pkg::ADV_LSB +: scl_pkg::ADV_W] = adv_reg;
         end
         else if (PADDR == scl_pkg::OFS_SPECIAL)
         begin
            prdata_next[scl_pkg::SM_IFMODE]                         = ifmode_reg; // RULE18
            prdata_next[scl_pkg::SM_MODE_LSB +: 3]                  = mode_reg;
            prdata_next[scl_pkg::SM_ADDR_LSB +: scl_pkg::PHY_ADDR_W] = addr_reg;
         end
         else if (PADDR == scl_pkg::OFS_STRAP_STAT)
         begin
            prdata_next[scl_pkg::STRAP_W-1:0] = cap_reg;
         end
         else
         begin
            perr_next = 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      cap_reg <= cap_next;
      if (RST_I)
      begin
         in_rst_d_reg <= 1'b1;
         rx_oe_reg    <= 1'b0;
         addr_reg     <= {2'h0, scl_pkg::STRAP_DEFAULT[scl_pkg::STR_ADDR_LSB +: 3]};
         mode_reg     <= scl_pkg::STRAP_DEFAULT[scl_pkg::STR_MODE_LSB +: 3];
         ifmode_reg   <= 1'b0;
         speed_reg    <= 1'b0;
         an_reg       <= 1'b0;
         iso_reg      <= 1'b0;
         dup_reg      <= 1'b0;
         pdown_reg    <= 1'b0;
         adv_reg      <= scl_pkg::ADV_RESET;
         rep_reg      <= 1'b0;
         crs_reg      <= 1'b0;
         match_reg    <= 1'b0;
         pready_reg   <= 1'b0;
         perr_reg     <= 1'b0;
         prdata_reg   <= 32'h0000_0000;
      end
      else
      begin
         in_rst_d_reg <= in_reset;
         rx_oe_reg    <= rx_oe_next;
         addr_reg     <= addr_next;
         mode_reg     <= mode_next;
         ifmode_reg   <= ifmode_next;
         speed_reg    <= speed_next;
         an_reg       <= an_next;
         iso_reg      <= iso_next;
         dup_reg      <= dup_next;
         pdown_reg    <= pdown_next;
         adv_reg      <= adv_next;
         rep_reg      <= rep_next;
         crs_reg      <= crs_next;
         match_reg    <= match_next;
         pready_reg   <= pready_next;
         perr_reg     <= perr_next;
         prdata_reg   <= prdata_next;
      end
   end

   assign RX_OE_O             = rx_oe_reg;
   assign MGMT_ADDR_MATCH_O   = match_reg;
   assign PHY_ADDR_O          = addr_reg;
   assign SCRAMBLER_SEED_O    = addr_reg;                             // RULE4
   assign SPEED_100_O         = speed_reg;
   assign AUTONEG_EN_O        = an_reg;
   assign ISOLATE_O           = iso_reg;
   assign FULL_DUPLEX_O       = dup_reg;
   assign POWER_DOWN_O        = pdown_reg;
   assign ADVERT_O            = adv_reg;
   assign REPEATER_O          = rep_reg;
   assign MEDIA_IF_MODE_BIT_O = ifmode_reg;
   assign CRS_O               = crs_reg;
   assign PRDATA              = prdata_reg;
   assign PREADY              = pready_reg;
   assign PSLVERR             = perr_reg;

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);

   chk_drivers_off: assert property (in_reset |=> !RX_OE_O) // RULE19
      else $error("Shared pins driven during reset");
   chk_addr_load: assert property                            // RULE2
      (release_evt |=> PHY_ADDR_O == {2'h0, $past(cap_reg[2:0])} && SCRAMBLER_SEED_O == PHY_ADDR_O)
      else $error("Strap address not loaded");
   chk_frame_match: assert property                          // RULE3
      (MGMT_FRAME_VALID_I && MGMT_FRAME_ADDR_I != addr_reg |=> !MGMT_ADDR_MATCH_O)
      else $error("Answered a foreign address");
   chk_soft_addr: assert property                            // RULE5
      (wr_acc && PADDR == scl_pkg::OFS_SPECIAL && !release_evt
       |=> PHY_ADDR_O == $past(PWDATA[4:0]))
      else $error("Written address not taken");
   chk_forced_10m: assert property                           // RULE9
      (release_evt && cap_mode == scl_pkg::MODE_10_FULL
       |=> !SPEED_100_O && !AUTONEG_EN_O && FULL_DUPLEX_O)
      else $error("Mode 001 loaded wrongly");
   chk_forced_100m: assert property                          // RULE10
      (release_evt && cap_mode == scl_pkg::MODE_100_HALF
       |=> SPEED_100_O && !AUTONEG_EN_O && !FULL_DUPLEX_O)
      else $error("Mode 010 loaded wrongly");
   chk_an_half: assert property                              // RULE12
      (release_evt && cap_mode[2:1] == 2'h2
       |=> AUTONEG_EN_O && ADVERT_O == scl_pkg::ADV_100_HALF
           ##1 $stable(ADVERT_O) || $past(wr_acc))
      else $error("Negotiated half mode loaded wrongly");
   chk_pdown_exit: assert property                           // RULE14
      (soft_rst && mode_reg != scl_pkg::MODE_POWER_DOWN |=> !POWER_DOWN_O)
      else $error("Power-down kept after soft reset");
   chk_crs_half: assert property                             // RULE11
      (TX_ACTIVE_I && !dup_reg && !rep_reg |=> CRS_O)
      else $error("Carrier sense missing on transmit");
   chk_if_select: assert property                            // RULE18
      (release_evt |=> MEDIA_IF_MODE_BIT_O == $past(cap_reg[6]))
      else $error("Interface mode bit not loaded");
   chk_strap_hold: assert property (!in_reset |=> $stable(cap_reg)) // RULE8 RULE19
      else $error("Strap capture changed outside reset");
   chk_match_pulse: assert property                          // RULE3
      (MGMT_FRAME_VALID_I && MGMT_FRAME_ADDR_I == addr_reg && !in_reset |=> MGMT_ADDR_MATCH_O)
      else $error("Own address not answered");
   chk_all_cap: assert property                              // RULE15
      (release_evt && cap_mode == scl_pkg::MODE_ALL_CAP
       |=> AUTONEG_EN_O && ADVERT_O == scl_pkg::ADV_ALL_CAP)
      else $error("Mode 111 loaded wrongly");
   chk_repeater_load: assert property                        // RULE13
      (release_evt && cap_mode == scl_pkg::MODE_REPEATER
       |=> REPEATER_O && !FULL_DUPLEX_O)
      else $error("Repeater mode loaded wrongly");

endmodule // scl_strap_latch

// ### tb/scl_strap_board.sv
`timescale 1ns/1ps
module scl_strap_board
(
   // Clock and driver state of the device
   input  wire logic       clk_i,
   input  wire logic       rx_oe_i,
   // Strap resistor choice
   input  wire logic [2:0] addr_i,
   input  wire logic [2:0] mode_i,
   input  wire logic       rmii_i,
   // Shared receive pins
   output logic            rx_err_o,
   output logic            rx_clk_o,
   output logic [3:0]      rxd_o,
   output logic            col_o,
   output logic            rmii_o
);
   logic flip;
   initial flip = 1'b0;
   always @(posedge clk_i) flip <= ~flip;
   // Resistors set the level only while the device drivers are off
   always_comb
   begin
      if (!rx_oe_i)
      begin
         {rxd_o[3], rx_clk_o, rx_err_o} = addr_i;
         {col_o, rxd_o[1], rxd_o[0]} = mode_i;
         rxd_o[2] = 1'b0;
         rmii_o = rmii_i;
      end
      else
      begin
         // Toggling pins catch a capture that keeps sampling after reset
         {rx_err_o, rx_clk_o, rxd_o, col_o, rmii_o} = {8{flip}} ^ 8'hA5;
      end
   end
endmodule // scl_strap_board

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   logic        clk, rst, pin_rst_n, rx_err, rx_clkp, col, rmii_pin, rx_oe;
   logic [3:0]  rxd, adv;
   logic        tx_act, rx_act, fv, match, spd, an, iso, dup, pdn, rep, ifm, crs;
   logic [4:0]  fa, phy_addr, seed;
   logic        psel, pen, pwr, pready, pslverr, s_rmii, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  s_addr, s_mode;
   int          err_total, total_checks, cycles;

   scl_strap_board scl_strap_board_i (.clk_i(clk), .rx_oe_i(rx_oe), .addr_i(s_addr),
      .mode_i(s_mode), .rmii_i(s_rmii), .rx_err_o(rx_err), .rx_clk_o(rx_clkp),
      .rxd_o(rxd), .col_o(col), .rmii_o(rmii_pin));
   scl_strap_latch scl_strap_latch_i (.CLK_SYS_I(clk), .RST_I(rst), .PIN_RESET_N_I(pin_rst_n),
      .RX_ERR_I(rx_err), .RX_CLK_PIN_I(rx_clkp), .RXD_I(rxd), .COL_CRSDV_I(col),
      .REDUCED_IF_SELECT_STRAP_I(rmii_pin), .RX_OE_O(rx_oe), .TX_ACTIVE_I(tx_act),
      .RX_ACTIVE_I(rx_act), .MGMT_FRAME_VALID_I(fv), .MGMT_FRAME_ADDR_I(fa),
      .MGMT_ADDR_MATCH_O(match), .PHY_ADDR_O(phy_addr), .SCRAMBLER_SEED_O(seed),
      .SPEED_100_O(spd), .AUTONEG_EN_O(an), .ISOLATE_O(iso), .FULL_DUPLEX_O(dup),
      .POWER_DOWN_O(pdn), .ADVERT_O(adv), .REPEATER_O(rep), .MEDIA_IF_MODE_BIT_O(ifm),
      .CRS_O(crs), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask

   task automatic strap_reset(input logic [2:0] a, input logic [2:0] m, input logic r);
      @(posedge clk);
      s_addr <= a; s_mode <= m; s_rmii <= r; rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic match_chk(input logic [4:0] a, input logic exp);
      @(posedge clk);
      fv <= 1'b1; fa <= a;
      @(posedge clk);
      fv <= 1'b0;
      @(negedge clk);
      chk8(8'(match), 8'(exp));
   endtask

   function automatic logic [3:0] exp_ctrl(input logic [2:0] m);
      case (m)
         3'h0: return 4'h0;
         3'h1: return 4'h1;
         3'h2: return 4'h8;
         3'h3: return 4'h9;
         3'h4, 3'h5: return 4'hC;
         default: return 4'hD;
      endcase
   endfunction

   task automatic check_cfg(input logic [2:0] a, input logic [2:0] m, input logic r);
      logic [3:0] c;
      c = exp_ctrl(m);
      chk8(8'({spd, an, iso, dup}), 8'(c));
      chk8(8'(adv), (m == 3'h4 || m == 3'h5) ? 8'h04 : 8'h0F);
      chk8(8'({pdn, rep}), {6'h0, m == 3'h6, m == 3'h5});
      chk8(8'(phy_addr), 8'(a));
      chk8(8'(seed), 8'(a));
      chk8(8'(ifm), 8'(r));
      @(posedge clk);
      tx_act <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk8(8'(crs), 8'(!c[0] && m != 3'h5));
      @(posedge clk);
      tx_act <= 1'b0; rx_act <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk8(8'(crs), 8'h01);
      @(posedge clk);
      rx_act <= 1'b0;
      match_chk({2'b00, a}, 1'b1);
      match_chk({2'b01, a}, 1'b0);
      apb(1'b0, 8'h0C, 32'h0);
      chk32(rd, {25'h0, r, m, a});
      apb(1'b0, 8'h08, 32'h0);
      chk32(rd, {17'h0, r, 6'h0, m, 2'b00, a});
   endtask

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         final_report();
      end
   end

   initial
   begin
      {rst, pin_rst_n, tx_act, rx_act, fv, psel, pen, pwr} = 8'hC0;
      {fa, paddr, pwdata, s_addr, s_mode, s_rmii} = '0;
      for (int m = 0; m < 8; m++)
      begin
         strap_reset(3'(7 - m), 3'(m), m[0]);
         check_cfg(3'(7 - m), 3'(m), m[0]);
         $display("test mode %0d done", m);
      end
      strap_reset(3'h2, 3'h6, 1'b0);
      chk8(8'(pdn), 8'h01);
      apb(1'b1, 8'h08, 32'h0000_0012);
      apb(1'b1, 8'h00, 32'h0000_A100);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk8(8'({pdn, spd, an, iso, dup}), 8'h09);
      chk8(8'(seed), 8'h12);
      match_chk(5'h12, 1'b1);
      match_chk(5'h02, 1'b0);
      apb(1'b0, 8'h10, 32'h0);
      chk32(rd, 32'h0);
      chk8(8'(er), 8'h01);
      $display("test soft reset done");
      @(posedge clk);
      s_addr <= 3'h5; s_mode <= 3'h2; pin_rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      pin_rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk8(8'({spd, an, iso, dup}), 8'h08);
      chk8(8'(phy_addr), 8'h05);
      $display("test pin reset done");
      final_report();
   end
endmodule // testbench
